// ==== rtl/spe_defs.svh ====
// Constants of the scan packet engine: encodings, offsets, reset values.
`ifndef SPE_DEFS_SVH
`define SPE_DEFS_SVH

// ****************************************************************
// Opcode byte fields
// ****************************************************************
`define SPE_OP_CLASS_HI     7
`define SPE_OP_CLASS_LO     5
`define SPE_OP_CLASS_SCAN   3'h4
`define SPE_OP_LAST_TMS     3
`define SPE_OP_CAPTURE      2
`define SPE_OP_FIXED_LEVEL  1
`define SPE_OP_USE_FIXED    0

// ****************************************************************
// Length byte fields
// ****************************************************************
`define SPE_LEN_PACKED      7
`define SPE_LEN_FIELD_HI    6
`define SPE_LEN_PACKED_MAX  6
`define SPE_LEN_ONE         8'h01

// ****************************************************************
// Register map (byte addresses) and reset values
// ****************************************************************
`define SPE_ADDR_CTRL       8'h00
`define SPE_ADDR_STATUS     8'h04
`define SPE_CTRL_ENABLE     0
`define SPE_CTRL_HALF_HI    15
`define SPE_CTRL_HALF_LO    8
`define SPE_CTRL_RESET      32'h0000_0400
`define SPE_CTRL_MASK       32'h0000_FF01
`define SPE_ST_BUSY         0
`define SPE_ST_STALLED      1
`define SPE_ST_CAPTURE      2
`define SPE_ST_LEN_LO       8

// ****************************************************************
// Timing: TCK half period in engine clocks
// ****************************************************************
// The TDO synchroniser is two stages deep, so a half period must
// exceed that latency for the sample to belong to the right cycle.
`define SPE_HALF_MIN        8'h04

`endif

// ==== rtl/spe_pkg.sv ====
// Types shared by the scan packet engine.
package spe_pkg;

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [2:0] {
        SPE_IDLE = 3'b000,
        SPE_LEN  = 3'b001,
        SPE_DATA = 3'b010,
        SPE_LO   = 3'b011,
        SPE_HI   = 3'b100,
        SPE_PUSH = 3'b101
    } spe_state_e;

endpackage : spe_pkg

// ==== rtl/spe_tck_gen.sv ====
// Half-period tick divider for the TCK waveform.
`timescale 1ns/1ns
`include "spe_defs.svh"

module spe_tck_gen (
    input  wire logic       ref_clk,     // Engine clock
    input  wire logic       rst_b,       // Asynchronous reset, active low
    input  wire logic       run,         // Count while a scan phase runs
    input  wire logic [7:0] half_cycles, // Requested half period
    output logic            tick         // One-cycle end of half period
);

    logic [7:0] cnt_reg;
    logic [7:0] half_eff;

    // Short settings are raised to the floor the TDO path needs
    assign half_eff = (half_cycles < `SPE_HALF_MIN) ? `SPE_HALF_MIN
                                                    : half_cycles;
    assign tick     = run && (cnt_reg == half_eff - 8'h01);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 8'h00;
        end else if (!run || tick) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

endmodule : spe_tck_gen

// ==== rtl/scan_packet_engine.sv ====
// Scan packet decoder and TCK/TMS/TDI sequencer with TDO capture.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`include "spe_defs.svh"

module scan_packet_engine
    import spe_pkg::*;
(
    input  wire logic        ref_clk,    // Engine clock, 125 MHz
    input  wire logic        rst_b,      // Asynchronous reset, active low
    input  wire logic [7:0]  reg_addr,   // Register byte address
    input  wire logic [31:0] reg_wdata,  // Register write data
    input  wire logic        reg_wr,     // Register write strobe
    input  wire logic        reg_rd,     // Register read strobe
    output logic      [31:0] reg_rdata,  // Read data, cycle after strobe
    input  wire logic        cmd_valid,  // Command byte available
    input  wire logic [7:0]  cmd_data,   // Command byte
    output logic             cmd_ready,  // Command byte taken when valid
    output logic             rsp_valid,  // Response byte offered
    output logic      [7:0]  rsp_data,   // Response byte
    input  wire logic        rsp_ready,  // Response FIFO has space
    output logic             tck,        // Test clock to the ports
    output logic             tms,        // Test mode select
    output logic             tdi,        // Test data toward the ports
    input  wire logic        tdo         // Test data from the ports, async
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Position of the data start flag; zero when no flag is present
    function automatic logic [7:0] packed_length(input logic [7:0] b);
        logic [7:0] n;
        n = 8'h00;
        for (int i = 1; i <= `SPE_LEN_PACKED_MAX; i++) begin
            if (b[i]) begin
                n = 8'(i);
            end
        end
        return n;
    endfunction : packed_length

    // ****************************************************************
    // Declarations
    // ****************************************************************
    spe_state_e  state_reg;
    spe_state_e  state_next;
    logic [31:0] ctrl_reg;
    logic [31:0] rdata_reg;
    logic [7:0]  opcode_reg;
    logic [7:0]  len_reg;
    logic [7:0]  bit_cnt_reg;
    logic [7:0]  tdi_sr_reg;
    logic [7:0]  cap_sr_reg;
    logic [7:0]  rsp_data_reg;
    logic        data_mode_reg;
    logic        tck_reg;
    logic        tms_reg;
    logic        tdi_reg;
    logic        tdo_meta_reg;
    logic        tdo_sync_reg;
    logic        enable;
    logic        tick;
    logic        take;
    logic        is_scan_op;
    logic        len_is_packed;
    logic [7:0]  len_decoded;
    logic        last_cycle;
    logic        next_last;
    logic        next_byte_edge;
    logic        byte_done;
    logic        capture;
    logic        use_fixed;
    logic        in_shift;
    logic [7:0]  bit_cnt_inc;
    logic [7:0]  cap_with_sample;

    // ****************************************************************
    // Decode
    // ****************************************************************
    assign enable        = ctrl_reg[`SPE_CTRL_ENABLE];
    assign take          = cmd_valid && cmd_ready;
    assign is_scan_op    = cmd_data[`SPE_OP_CLASS_HI:`SPE_OP_CLASS_LO]
                           == `SPE_OP_CLASS_SCAN;
    assign len_is_packed = cmd_data[`SPE_LEN_PACKED];
    // Normal field holds length minus one, giving 1 to 128 cycles
    assign len_decoded   = len_is_packed ? packed_length(cmd_data)
                         : {1'b0, cmd_data[`SPE_LEN_FIELD_HI:0]}
                           + `SPE_LEN_ONE;
    assign capture       = opcode_reg[`SPE_OP_CAPTURE];
    assign use_fixed     = opcode_reg[`SPE_OP_USE_FIXED];
    assign in_shift      = (state_reg == SPE_LO) || (state_reg == SPE_HI);
    assign bit_cnt_inc   = bit_cnt_reg + 8'h01;
    assign last_cycle    = bit_cnt_inc == len_reg;
    assign next_last     = bit_cnt_reg == len_reg;
    assign next_byte_edge = bit_cnt_reg[2:0] == 3'h0;
    assign byte_done     = (bit_cnt_inc[2:0] == 3'h0) || last_cycle;

    always_comb begin
        cap_with_sample = cap_sr_reg;
        cap_with_sample[bit_cnt_reg[2:0]] = tdo_sync_reg;
    end

    // ****************************************************************
    // TCK divider
    // ****************************************************************
    spe_tck_gen u_tck_gen (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .run         (in_shift),
        .half_cycles (ctrl_reg[`SPE_CTRL_HALF_HI:`SPE_CTRL_HALF_LO]),
        .tick        (tick)
    );

    // ****************************************************************
    // TDO synchroniser
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tdo_meta_reg <= 1'b0;
            tdo_sync_reg <= 1'b0;
        end else begin
            tdo_meta_reg <= tdo;
            tdo_sync_reg <= tdo_meta_reg;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // Bytes are only taken between scans or at byte boundaries of a
    // data scan, so a slow source simply lengthens the low phase.
    assign cmd_ready = enable && ((state_reg == SPE_IDLE) ||
                                  (state_reg == SPE_LEN)  ||
                                  (state_reg == SPE_DATA));

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SPE_IDLE: begin
                // Bytes of other packet kinds are not handled here
                if (take && is_scan_op) begin
                    state_next = SPE_LEN;
                end
            end
            SPE_LEN: begin
                if (take) begin
                    if (len_decoded == 8'h00) begin
                        state_next = SPE_IDLE;
                    end else if (!len_is_packed && !use_fixed) begin
                        state_next = SPE_DATA;
                    end else begin
                        state_next = SPE_LO;
                    end
                end
            end
            SPE_DATA: begin
                if (take) begin
                    state_next = SPE_LO;
                end
            end
            SPE_LO: begin
                if (tick) begin
                    state_next = SPE_HI;
                end
            end
            SPE_HI: begin
                if (tick) begin
                    if (capture && byte_done) begin
                        state_next = SPE_PUSH;
                    end else if (last_cycle) begin
                        state_next = SPE_IDLE;
                    end else if (data_mode_reg &&
                                 bit_cnt_inc[2:0] == 3'h0) begin
                        state_next = SPE_DATA;
                    end else begin
                        state_next = SPE_LO;
                    end
                end
            end
            SPE_PUSH: begin
                // No tick runs here, so TCK stays low while stalled
                if (rsp_ready) begin
                    if (next_last) begin
                        state_next = SPE_IDLE;
                    end else if (data_mode_reg && next_byte_edge) begin
                        state_next = SPE_DATA;
                    end else begin
                        state_next = SPE_LO;
                    end
                end
            end
            default: begin
                state_next = SPE_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= SPE_IDLE;
        end else if (!enable && !in_shift && state_reg != SPE_PUSH) begin
            state_reg <= SPE_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Packet header and length
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            opcode_reg    <= 8'h00;
            len_reg       <= 8'h00;
            data_mode_reg <= 1'b0;
        end else if (take && state_reg == SPE_IDLE) begin
            opcode_reg <= cmd_data;
        end else if (take && state_reg == SPE_LEN) begin
            len_reg       <= len_decoded;
            data_mode_reg <= !len_is_packed && !use_fixed;
        end
    end

    // ****************************************************************
    // Input data register and cycle counter
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tdi_sr_reg <= 8'h00;
        end else if (take && state_reg == SPE_LEN) begin
            tdi_sr_reg <= cmd_data;
        end else if (take && state_reg == SPE_DATA) begin
            tdi_sr_reg <= cmd_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt_reg <= 8'h00;
        end else if (take && state_reg == SPE_LEN) begin
            bit_cnt_reg <= 8'h00;
        end else if (state_reg == SPE_HI && tick) begin
            bit_cnt_reg <= bit_cnt_inc;
        end
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tck_reg <= 1'b0;
        end else begin
            tck_reg <= state_reg == SPE_HI;
        end
    end

    // TDI and TMS change only while TCK is low
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tms_reg <= 1'b0;
            tdi_reg <= 1'b0;
        end else if (state_reg == SPE_LO) begin
            tms_reg <= last_cycle &&
                       opcode_reg[`SPE_OP_LAST_TMS];
            if (use_fixed) begin
                tdi_reg <= opcode_reg[`SPE_OP_FIXED_LEVEL];
            end else begin
                tdi_reg <= tdi_sr_reg[bit_cnt_reg[2:0]];
            end
        end
    end

    // ****************************************************************
    // Response capture
    // ****************************************************************
    // Sampling at the end of the high phase reads TDO two clocks back,
    // which is still inside the high phase given the half-period floor.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cap_sr_reg <= 8'h00;
        end else if (take && state_reg == SPE_LEN) begin
            cap_sr_reg <= 8'h00;
        end else if (state_reg == SPE_HI && tick && capture) begin
            if (byte_done) begin
                cap_sr_reg <= 8'h00;
            end else begin
                cap_sr_reg <= cap_with_sample;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_data_reg <= 8'h00;
        end else if (state_reg == SPE_HI && tick && capture && byte_done) begin
            rsp_data_reg <= cap_with_sample;
        end
    end

    assign rsp_valid = state_reg == SPE_PUSH;
    assign rsp_data  = rsp_data_reg;
    assign tck       = tck_reg;
    assign tms       = tms_reg;
    assign tdi       = tdi_reg;

    // ****************************************************************
    // Register port
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= `SPE_CTRL_RESET;
        end else if (reg_wr && reg_addr == `SPE_ADDR_CTRL) begin
            ctrl_reg <= reg_wdata & `SPE_CTRL_MASK;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 32'h0000_0000;
        end else if (reg_rd) begin
            if (reg_addr == `SPE_ADDR_CTRL) begin
                rdata_reg <= ctrl_reg;
            end else if (reg_addr == `SPE_ADDR_STATUS) begin
                rdata_reg <= 32'h0000_0000;
                rdata_reg[`SPE_ST_BUSY]    <= state_reg != SPE_IDLE;
                rdata_reg[`SPE_ST_STALLED] <= rsp_valid && !rsp_ready;
                rdata_reg[`SPE_ST_CAPTURE] <= capture;
                rdata_reg[`SPE_ST_LEN_LO +: 8] <= bit_cnt_reg;
            end else begin
                rdata_reg <= 32'h0000_0000;
            end
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule : scan_packet_engine

// ==== sim/spe_checker.sv ====
// Port assertions of the scan packet engine.
`timescale 1ns/1ns

module spe_checker (
    input wire logic        ref_clk,   // Clock
    input wire logic        rst_b,     // Reset
    input wire logic [7:0]  reg_addr,  // Address
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic        reg_wr,    // Write strobe
    input wire logic        reg_rd,    // Read strobe
    input wire logic [31:0] reg_rdata, // Read data
    input wire logic        cmd_valid, // Byte offered
    input wire logic [7:0]  cmd_data,  // Byte
    input wire logic        cmd_ready, // Byte taken
    input wire logic        rsp_valid, // Response offered
    input wire logic [7:0]  rsp_data,  // Response
    input wire logic        rsp_ready, // Response space
    input wire logic        tck,       // Test clock
    input wire logic        tms,       // Mode select
    input wire logic        tdi,       // Data out
    input wire logic        tdo        // Data in
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence stalled;
        rsp_valid && !rsp_ready;
    endsequence
    sequence ctrl_read;
        reg_rd && reg_addr == 8'h00;
    endsequence
    sequence gap_read;
        reg_rd && reg_addr != 8'h00 && reg_addr != 8'h04;
    endsequence

    chk_stall_no_tck: assert property (stalled |=> !tck)
        else $error("tck high while the response is stalled");
    chk_stall_pins: assert property (stalled |=> $stable(tdi))
        else $error("tdi moved while the response is stalled");
    chk_rsp_hold: assert property (
        stalled |=> rsp_valid && $stable(rsp_data))
        else $error("response byte dropped or changed before taken");
    chk_rsp_at_fall: assert property (
        $rose(rsp_valid) |=> $fell(tck))
        else $error("response byte not offered at end of a cycle");
    chk_pins_high: assert property (
        tck |-> $stable(tdi) && $stable(tms))
        else $error("tdi or tms changed while tck high");
    chk_busy_rise: assert property ($rose(tck) |-> !cmd_ready)
        else $error("command byte accepted while shifting");
    chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 0)
        else $error("read data outside the answer cycle");
    chk_gap_zero: assert property (gap_read |=> reg_rdata == 0)
        else $error("unmapped address read not zero");
    chk_ctrl_mask: assert property (
        ctrl_read |=> (reg_rdata & ~32'h0000_FF01) == 0)
        else $error("control register unused bits not zero");
endmodule : spe_checker

bind scan_packet_engine spe_checker spe_checker_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_ready(rsp_ready), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo)
);

// ==== sim/spe_tap_model.sv ====
// Behavioural test port chain: records pins, plays a fixed TDO pattern.
`timescale 1ns/1ns

module spe_tap_model #(
    parameter logic [127:0] PATTERN = 128'h0
) (
    input  wire logic         tck,      // Test clock
    input  wire logic         tms,      // Mode select
    input  wire logic         tdi,      // Data toward the ports
    input  wire logic         clear,    // Restart the cycle count
    output logic              tdo,      // Data from the ports
    output logic      [7:0]   count,    // Completed TCK cycles
    output logic      [127:0] tdi_seen, // TDI per cycle
    output logic      [127:0] tms_seen  // TMS per cycle
);
    always @(posedge tck) begin
        tdi_seen[count[6:0]] <= tdi;
        tms_seen[count[6:0]] <= tms;
    end

    // TDO moves on the falling edge so it is steady while tck is high
    always @(negedge tck or posedge clear) begin
        if (clear) begin
            count <= 8'h00;
            tdo   <= PATTERN[0];
        end else begin
            count <= count + 8'h01;
            tdo   <= PATTERN[count[6:0] + 7'h01];
        end
    end
endmodule : spe_tap_model

// ==== sim/scan_packet_engine_test.sv ====
// Self-checking bench of the scan packet engine against a port model.
`timescale 1ns/1ns

`define SPE_CHECK(nm, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("BAD %s exp %0h got %0h", nm, exp, got); \
        end \
    end

module scan_packet_engine_test;
    typedef struct packed {
        logic [7:0]   op;
        logic [7:0]   lb;
        logic [7:0]   len;
        logic [127:0] dat;
    } spe_row_s;

    localparam logic [127:0] PAT =
        128'h3C5A_96E1_0FF0_A5C3_1248_7EDB_6D92_C3A5;

    // Opcode, length byte, expected cycles, data bytes
    spe_row_s rows [13] = '{
        '{8'h80, 8'h83, 8'h01, 128'h0},
        '{8'h84, 8'hC5, 8'h06, 128'h0},
        '{8'h8C, 8'hA9, 8'h05, 128'h0},
        '{8'h84, 8'h96, 8'h04, 128'h0},
        '{8'h8C, 8'h8D, 8'h03, 128'h0},
        '{8'h84, 8'h86, 8'h02, 128'h0},
        '{8'h87, 8'h8F, 8'h03, 128'h0},
        '{8'h8C, 8'h14, 8'h15, 128'h1A_C35E},
        '{8'h89, 8'h7F, 8'h80, 128'h0},
        '{8'h86, 8'h07, 8'h08, 128'hB4},
        '{8'h84, 8'h08, 8'h09, 128'h0196},
        '{8'h8C, 8'h7F, 8'h80, 128'hF0E1_D2C3_B4A5_9687_7869_5A4B_3C2D_1E0F},
        '{8'h80, 8'h00, 8'h01, 128'h01}
    };

    logic         ref_clk, rst_b, reg_wr, reg_rd, cmd_valid, rsp_ready;
    logic         tdo, clear, tck, tms, tdi, cmd_ready, rsp_valid;
    logic [7:0]   reg_addr, cmd_data, rsp_data, count;
    logic [31:0]  reg_wdata, reg_rdata;
    logic [127:0] tdi_seen, tms_seen;
    int           fail_count, tests_run, rsp_seen;

    scan_packet_engine scan_packet_engine_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_ready(rsp_ready), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    // A single port on the chain keeps captured data defined
    spe_tap_model #(.PATTERN(PAT)) spe_tap_model_i (
        .tck(tck), .tms(tms), .tdi(tdi), .clear(clear), .tdo(tdo),
        .count(count), .tdi_seen(tdi_seen), .tms_seen(tms_seen));

    always @(posedge ref_clk) begin
        if (rsp_valid && rsp_ready) rsp_seen++;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic stop_test();
        if (fail_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    task automatic give_up();
        fail_count++;
        stop_test();
    endtask : give_up

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    // Valid stays up between bytes; the caller lowers it after the last
    task automatic send_byte(input logic [7:0] b);
        int n;
        cmd_data  <= b;
        cmd_valid <= 1'b1;
        for (n = 0; n < 3000; n++) begin
            @(negedge ref_clk);
            if (cmd_ready === 1'b1) break;
        end
        if (n == 3000) give_up();
        @(posedge ref_clk);
    endtask : send_byte

    task automatic get_rsp(input int nb, output logic [127:0] got);
        int k, n;
        got = '0;
        for (k = 0; k < nb; k++) begin
            for (n = 0; n < 3000; n++) begin
                @(negedge ref_clk);
                if (rsp_valid === 1'b1 && rsp_ready === 1'b1) break;
            end
            if (n == 3000) give_up();
            got[k*8 +: 8] = rsp_data;
            @(posedge ref_clk);
        end
    endtask : get_rsp

    task automatic run_row(input spe_row_s r);
        int           len, nb, i, n;
        logic [127:0] etdi, etms, ersp, got, m;
        logic [31:0]  st;
        len  = r.len;
        nb   = (len + 7) / 8;
        m    = (128'h1 << len) - 128'h1;
        etdi = '0;
        etms = '0;
        for (i = 0; i < len; i++)
            etdi[i] = r.op[0] ? r.op[1] : (r.lb[7] ? r.lb[i] : r.dat[i]);
        etms[len-1] = r.op[3];
        ersp = PAT & m;
        rsp_seen = 0;
        clear <= 1'b1;
        @(posedge ref_clk);
        clear <= 1'b0;
        fork
            begin
                send_byte(r.op);
                send_byte(r.lb);
                if (!r.lb[7] && !r.op[0])
                    for (i = 0; i < nb; i++) send_byte(r.dat[i*8 +: 8]);
                cmd_valid <= 1'b0;
            end
            if (r.op[2]) get_rsp(nb, got);
        join
        for (n = 0; n < 5000 && count !== r.len; n++) @(posedge ref_clk);
        if (n == 5000) give_up();
        reg_read(8'h04, st);
        `SPE_CHECK("cycles", r.len, count)
        `SPE_CHECK("tdi", etdi, tdi_seen & m)
        `SPE_CHECK("tms", etms, tms_seen & m)
        `SPE_CHECK("busy", 1'b0, st[0])
        `SPE_CHECK("rsp count", r.op[2] ? nb : 0, rsp_seen)
        if (r.op[2]) `SPE_CHECK("rsp", ersp, got)
    endtask : run_row

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        logic [31:0] d;
        int          n;
        rst_b     = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        cmd_valid = 1'b0;
        cmd_data  = 8'h00;
        rsp_ready = 1'b1;
        clear     = 1'b1;
        repeat (8) @(posedge ref_clk);
        `SPE_CHECK("tck in reset", 1'b0, tck)
        `SPE_CHECK("ready in reset", 1'b0, cmd_ready)
        rst_b <= 1'b1;
        clear <= 1'b0;
        reg_read(8'h00, d);
        `SPE_CHECK("ctrl reset", 32'h0000_0400, d)
        reg_write(8'h00, 32'hFFFF_FFFF);
        reg_read(8'h00, d);
        `SPE_CHECK("ctrl mask", 32'h0000_FF01, d)
        reg_write(8'h10, 32'hFFFF_FFFF);
        reg_read(8'h10, d);
        `SPE_CHECK("gap read", 32'h0, d)
        reg_write(8'h00, 32'h0000_0401);
        foreach (rows[k]) run_row(rows[k]);
        // A reserved class byte is dropped; the next packet runs intact
        send_byte(8'hA0);
        cmd_valid <= 1'b0;
        run_row(rows[4]);
        // Full response FIFO at the first byte of a nine-cycle scan
        rsp_ready <= 1'b0;
        fork
            run_row(rows[10]);
            begin
                for (n = 0; n < 3000 && rsp_valid !== 1'b1; n++)
                    @(posedge ref_clk);
                if (n == 3000) give_up();
                repeat (40) @(posedge ref_clk);
                `SPE_CHECK("stall cycles", 8'h08, count)
                `SPE_CHECK("stall tck", 1'b0, tck)
                reg_read(8'h04, d);
                `SPE_CHECK("stall flag", 1'b1, d[1])
                `SPE_CHECK("stall capture", 1'b1, d[2])
                `SPE_CHECK("stall done", 8'h08, d[15:8])
                @(posedge ref_clk);
                rsp_ready <= 1'b1;
            end
        join
        stop_test();
    end
endmodule : scan_packet_engine_test
